// ---- isp_pkg.sv ----
// constants and types for the interface select and power mode block
// assumes an apb master on pclk with 8-bit byte addresses
`default_nettype none
package isp_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_IFACE  = 6'h0f;
    localparam logic [5:0] IDX_SYNC   = 6'h10;
    localparam logic [5:0] IDX_POWER  = 6'h14;
    localparam logic [5:0] IDX_DETECT = 6'h15;
    localparam logic [5:0] IDX_FORMAT = 6'h18;
    localparam logic [5:0] IDX_MODE   = 6'h19;

    localparam int OVR_BIT   = 2;
    localparam int SEL_BIT   = 1;
    localparam int HPOL_BIT  = 6;
    localparam int VPOL_BIT  = 2;
    localparam int PWRON_BIT = 1;
    localparam int DHS_BIT   = 7;
    localparam int DSOG_BIT  = 6;
    localparam int DVS_BIT   = 5;
    localparam int DCLK_BIT  = 4;
    localparam int F422_BIT  = 0;
    localparam int FVSC_BIT  = 1;
    localparam int FPH_LSB   = 2;
    localparam int FDIV_LSB  = 4;
    localparam int FHSW_LSB  = 8;
    localparam int MACT_LSB  = 8;

    localparam logic       RST_PWRON = 1'b1;
    localparam logic [1:0] RST_PHASE = 2'h0;
    localparam logic [3:0] RST_DIV   = 4'h3;
    localparam logic [7:0] RST_HSW   = 8'h10;
    localparam logic [9:0] RST_PWR   = 10'h001;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_ANA  = 2'h1;
    localparam logic [1:0] ACT_DIG  = 2'h2;

    // power_enable bit positions
    localparam int PW_SERIAL = 0;
    localparam int PW_DCLKDT = 1;
    localparam int PW_ANADT  = 2;
    localparam int PW_SOG    = 3;
    localparam int PW_BGAP   = 4;
    localparam int PW_ANA    = 5;
    localparam int PW_DIG    = 6;
    localparam int PW_RED    = 7;
    localparam int PW_GREEN  = 8;
    localparam int PW_BLUE   = 9;

    typedef enum logic [4:0] {
        MODE_OFF  = 5'h01,
        MODE_SEEK = 5'h02,
        MODE_A444 = 5'h04,
        MODE_A422 = 5'h08,
        MODE_DIG  = 5'h10
    } isp_mode_type;
endpackage
`default_nettype wire

// ---- isp_top.sv ----
// interface select, power mode and shared output stage
// assumes apb on pclk; detector status levels arrive asynchronously;
// pixel and sync inputs come from receiver logic on pclk
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module isp_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        det_hsync_active,
    input  wire logic        det_vsync_active,
    input  wire logic        det_sog_active,
    input  wire logic        det_link_clock,
    input  wire logic [23:0] ana_rgb,
    input  wire logic        ana_hsync,
    input  wire logic        ana_vsync,
    input  wire logic        ana_csync_vsync,
    input  wire logic [23:0] dig_rgb,
    input  wire logic        dig_hsync,
    input  wire logic        dig_vsync,
    output var  logic [7:0]  red,
    output var  logic [7:0]  green,
    output var  logic [7:0]  blue,
    output var  logic        recovered_hsync_out,
    output var  logic        vertical_sync_out,
    output var  logic        pixel_output_clock,
    output var  logic [9:0]  power_enable,
    output var  logic [1:0]  active_interface
);
    typedef struct packed {
        logic              ovr;
        logic              sel;
        logic              hpol;
        logic              vpol;
        logic              pwr_on;
        logic              fmt422;
        logic              vsc;
        logic [1:0]        phase;
        logic [3:0]        div;
        logic [7:0]        hsw;
        logic [3:0]        det_meta;
        logic [3:0]        det_sync;
        isp_pkg::isp_mode_type mode;
        logic [1:0]        active;
        logic [3:0]        div_cnt;
        logic              pix_clk;
        logic [23:0]       smp;
        logic              hs_prev;
        logic [7:0]        hs_cnt;
        logic [3:0][26:0]  pipe;
        logic [23:0]       rgb;
        logic              hs_o;
        logic              vs_o;
        logic              clk_o;
        logic [9:0]        pwr;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } isp_state_type;

    isp_state_type s;
    isp_state_type n;

    function automatic logic isp_reg_hit(input logic [5:0] idx);
        isp_reg_hit = (idx == isp_pkg::IDX_IFACE)
                   || (idx == isp_pkg::IDX_SYNC)
                   || (idx == isp_pkg::IDX_POWER)
                   || (idx == isp_pkg::IDX_DETECT)
                   || (idx == isp_pkg::IDX_FORMAT)
                   || (idx == isp_pkg::IDX_MODE);
    endfunction

    // returns {mode, active}
    function automatic logic [6:0] isp_decide(
        input logic pwr_on,
        input logic ovr,
        input logic sel,
        input logic a_det,
        input logic d_det,
        input logic f422
    );
        logic [4:0] amode;
        amode = f422 ? isp_pkg::MODE_A422 : isp_pkg::MODE_A444;
        if (!pwr_on) begin
            isp_decide = {isp_pkg::MODE_OFF, isp_pkg::ACT_NONE};
        end else if (ovr) begin
            if (sel) begin
                isp_decide = {isp_pkg::MODE_DIG, isp_pkg::ACT_DIG};
            end else begin
                isp_decide = {amode, isp_pkg::ACT_ANA};
            end
        end else if (!a_det && !d_det) begin
            isp_decide = {isp_pkg::MODE_SEEK, isp_pkg::ACT_NONE};
        end else if (!a_det) begin
            isp_decide = {isp_pkg::MODE_DIG, isp_pkg::ACT_DIG};
        end else if (!d_det) begin
            isp_decide = {amode, isp_pkg::ACT_ANA};
        end else if (sel) begin
            isp_decide = {isp_pkg::MODE_DIG, isp_pkg::ACT_DIG};
        end else begin
            isp_decide = {amode, isp_pkg::ACT_ANA};
        end
    endfunction

    function automatic logic [9:0] isp_power_mask(
        input isp_pkg::isp_mode_type mode
    );
        logic [9:0] m;
        m = '0;
        m[isp_pkg::PW_SERIAL] = 1'b1;
        unique case (mode)
            isp_pkg::MODE_OFF: begin
            end
            isp_pkg::MODE_SEEK: begin
                m[isp_pkg::PW_DCLKDT] = 1'b1;
                m[isp_pkg::PW_ANADT]  = 1'b1;
                m[isp_pkg::PW_SOG]    = 1'b1;
            end
            isp_pkg::MODE_DIG: begin
                m[isp_pkg::PW_DCLKDT] = 1'b1;
                m[isp_pkg::PW_ANADT]  = 1'b1;
                m[isp_pkg::PW_SOG]    = 1'b1;
                m[isp_pkg::PW_BGAP]   = 1'b1;
                m[isp_pkg::PW_DIG]    = 1'b1;
                m[isp_pkg::PW_RED]    = 1'b1;
                m[isp_pkg::PW_GREEN]  = 1'b1;
                m[isp_pkg::PW_BLUE]   = 1'b1;
            end
            isp_pkg::MODE_A444,
            isp_pkg::MODE_A422: begin
                m[isp_pkg::PW_DCLKDT] = 1'b1;
                m[isp_pkg::PW_ANADT]  = 1'b1;
                m[isp_pkg::PW_SOG]    = 1'b1;
                m[isp_pkg::PW_BGAP]   = 1'b1;
                m[isp_pkg::PW_ANA]    = 1'b1;
                m[isp_pkg::PW_RED]    = 1'b1;
                m[isp_pkg::PW_GREEN]  = 1'b1;
                m[isp_pkg::PW_BLUE]   = (mode == isp_pkg::MODE_A444);
            end
            default: begin
            end
        endcase
        isp_power_mask = m;
    endfunction

    logic [5:0]  idx;
    logic        a_det;
    logic        d_det;
    logic [6:0]  dec;
    logic        hs_act;
    logic [23:0] src_rgb;
    logic        src_hs;
    logic        src_vs;
    logic [23:0] gated;
    logic [31:0] rd;

    assign idx = paddr[7:2];

    always_comb begin
        n = s;
        rd = '0;
        // status bits 7..4 seen through two flops
        n.det_meta = {det_hsync_active, det_sog_active,
                      det_vsync_active, det_link_clock};
        n.det_sync = s.det_meta;
        a_det = |s.det_sync[3:1];
        d_det = s.det_sync[0];
        dec = isp_decide(s.pwr_on, s.ovr, s.sel, a_det, d_det, s.fmt422);
        n.mode = isp_pkg::isp_mode_type'(dec[6:2]);
        n.active = dec[1:0];
        n.pwr = isp_power_mask(s.mode);

        // divider: period div+1 cycles, or 2 cycles when div is 0; sample when count hits zero
        if (s.div_cnt == 4'h0) begin
            n.div_cnt = (s.div == 4'h0) ? 4'h1 : s.div;
        end else begin
            n.div_cnt = s.div_cnt - 4'h1;
        end
        n.pix_clk = (n.div_cnt > {1'b0, s.div[3:1]});

        // hsync rebuilt from the active edge of the analog sync
        hs_act = s.hpol ? ana_hsync : ~ana_hsync;
        n.hs_prev = hs_act;
        if (hs_act && !s.hs_prev) begin
            n.hs_cnt = s.hsw;
        end else if (s.hs_cnt != 8'h00) begin
            n.hs_cnt = s.hs_cnt - 8'h01;
        end

        unique case (s.active)
            isp_pkg::ACT_ANA: begin
                src_rgb = ana_rgb;
                src_hs = (s.hs_cnt != 8'h00);
                src_vs = s.vsc ? ana_csync_vsync : ana_vsync;
            end
            isp_pkg::ACT_DIG: begin
                src_rgb = dig_rgb;
                src_hs = dig_hsync;
                src_vs = dig_vsync;
            end
            default: begin
                src_rgb = '0;
                src_hs = 1'b0;
                src_vs = 1'b0;
            end
        endcase
        if (s.div_cnt == 4'h0) begin
            n.smp = src_rgb;
        end
        // unpowered buses read as zero; msb stays on bit 7 of each
        gated[23:16] = s.pwr[isp_pkg::PW_RED]   ? s.smp[23:16] : 8'h00;
        gated[15:8]  = s.pwr[isp_pkg::PW_GREEN] ? s.smp[15:8]  : 8'h00;
        gated[7:0]   = s.pwr[isp_pkg::PW_BLUE]  ? s.smp[7:0]   : 8'h00;

        // one delay line for clock, both syncs and pixels so a phase step keeps alignment
        n.pipe[0] = {s.pix_clk, src_hs, src_vs ^ s.vpol, gated};
        for (int i = 1; i < 4; i++) begin
            n.pipe[i] = s.pipe[i-1];
        end
        {n.clk_o, n.hs_o, n.vs_o, n.rgb} = s.pipe[s.phase];

        // apb: one wait state, error on unmapped index
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        unique case (idx)
            isp_pkg::IDX_IFACE: begin
                rd[isp_pkg::OVR_BIT] = s.ovr;
                rd[isp_pkg::SEL_BIT] = s.sel;
            end
            isp_pkg::IDX_SYNC: begin
                rd[isp_pkg::HPOL_BIT] = s.hpol;
                rd[isp_pkg::VPOL_BIT] = s.vpol;
            end
            isp_pkg::IDX_POWER: begin
                rd[isp_pkg::PWRON_BIT] = s.pwr_on;
            end
            isp_pkg::IDX_DETECT: begin
                rd[isp_pkg::DHS_BIT:isp_pkg::DCLK_BIT] = s.det_sync;
            end
            isp_pkg::IDX_FORMAT: begin
                rd[isp_pkg::F422_BIT] = s.fmt422;
                rd[isp_pkg::FVSC_BIT] = s.vsc;
                rd[isp_pkg::FPH_LSB +: 2] = s.phase;
                rd[isp_pkg::FDIV_LSB +: 4] = s.div;
                rd[isp_pkg::FHSW_LSB +: 8] = s.hsw;
            end
            isp_pkg::IDX_MODE: begin
                rd[4:0] = s.mode;
                rd[isp_pkg::MACT_LSB +: 2] = s.active;
            end
            default: begin
            end
        endcase
        if (psel && penable && !s.pready) begin
            n.pready = 1'b1;
            n.pslverr = !isp_reg_hit(idx);
            n.prdata = pwrite ? 32'h0000_0000 : rd;
        end
        if (psel && penable && s.pready && pwrite && isp_reg_hit(idx)) begin
            unique case (idx)
                isp_pkg::IDX_IFACE: begin
                    n.ovr = pwdata[isp_pkg::OVR_BIT];
                    n.sel = pwdata[isp_pkg::SEL_BIT];
                end
                isp_pkg::IDX_SYNC: begin
                    n.hpol = pwdata[isp_pkg::HPOL_BIT];
                    n.vpol = pwdata[isp_pkg::VPOL_BIT];
                end
                isp_pkg::IDX_POWER: begin
                    n.pwr_on = pwdata[isp_pkg::PWRON_BIT];
                end
                isp_pkg::IDX_FORMAT: begin
                    n.fmt422 = pwdata[isp_pkg::F422_BIT];
                    n.vsc = pwdata[isp_pkg::FVSC_BIT];
                    n.phase = pwdata[isp_pkg::FPH_LSB +: 2];
                    n.div = pwdata[isp_pkg::FDIV_LSB +: 4];
                    n.hsw = pwdata[isp_pkg::FHSW_LSB +: 8];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.pwr_on <= isp_pkg::RST_PWRON;
            s.phase <= isp_pkg::RST_PHASE;
            s.div <= isp_pkg::RST_DIV;
            s.hsw <= isp_pkg::RST_HSW;
            s.mode <= isp_pkg::MODE_OFF;
            s.active <= isp_pkg::ACT_NONE;
            s.pwr <= isp_pkg::RST_PWR;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign red = s.rgb[23:16];
    assign green = s.rgb[15:8];
    assign blue = s.rgb[7:0];
    assign recovered_hsync_out = s.hs_o;
    assign vertical_sync_out = s.vs_o;
    assign pixel_output_clock = s.clk_o;
    assign power_enable = s.pwr;
    assign active_interface = s.active;
endmodule
`default_nettype wire

// ---- isp_assertions.sv ----
// checker for the interface select and power mode block
// assumes it is bound to isp_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module isp_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [7:0]  red,
    input wire logic [7:0]  green,
    input wire logic [7:0]  blue,
    input wire logic        recovered_hsync_out,
    input wire logic        pixel_output_clock,
    input wire logic [9:0]  power_enable,
    input wire logic [1:0]  active_interface
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] hold_cnt;
    // saturates so a stuck clock cannot wrap back under the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 5'h00;
        end else if ($changed(pixel_output_clock) ||
                     active_interface == isp_pkg::ACT_NONE) begin
            hold_cnt <= 5'h00;
        end else if (hold_cnt != 5'h1f) begin
            hold_cnt <= hold_cnt + 5'h01;
        end
    end
    a_dig_power: assert property (
        (active_interface == isp_pkg::ACT_DIG)[*2] |->
        power_enable == 10'h3df) else $error("digital power set wrong");
    a_ana_power: assert property (
        (active_interface == isp_pkg::ACT_ANA)[*2] |->
        power_enable == 10'h3bf || power_enable == 10'h1bf)
        else $error("analog power set wrong");
    a_none_power: assert property (
        (active_interface == isp_pkg::ACT_NONE)[*2] |->
        power_enable == 10'h001 || power_enable == 10'h00f)
        else $error("idle power set wrong");
    a_serial_on: assert property (power_enable[isp_pkg::PW_SERIAL])
        else $error("serial bus unpowered");
    a_pwrdn_first: assert property (
        psel && penable && pready && pwrite && paddr == 8'h50 && !pwdata[1]
        |-> ##[1:3] power_enable == 10'h001)
        else $error("power down not taken");
    a_power_follows: assert property (
        $changed(active_interface) |=> $changed(power_enable))
        else $error("power did not follow interface change");
    a_none_quiet: assert property (
        (active_interface == isp_pkg::ACT_NONE)[*8] |->
        {red, green, blue} == 24'h0 && !recovered_hsync_out)
        else $error("outputs active with no interface");
    a_blue_off: assert property ((power_enable == 10'h1bf)[*8] |->
        blue == 8'h00) else $error("blue driven in 4:2:2");
    a_clock_runs: assert property (
        active_interface != isp_pkg::ACT_NONE |-> hold_cnt < 5'h14)
        else $error("data clock stalled");
endmodule
bind isp_top isp_checker isp_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .red(red), .green(green),
    .blue(blue), .recovered_hsync_out(recovered_hsync_out),
    .pixel_output_clock(pixel_output_clock), .power_enable(power_enable),
    .active_interface(active_interface));
`default_nettype wire

// ---- isp_scaler_model.sv ----
// downstream scaler model capturing pixels on the output data clock
// assumes the data clock is slow against pclk, so it is edge-detected
`timescale 1ns/10ps
`default_nettype none
module isp_scaler_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pixel_output_clock,
    input wire logic [7:0]  red,
    input wire logic [7:0]  green,
    input wire logic [7:0]  blue,
    output var logic [23:0] cap_rgb
);
    logic clk_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q   <= 1'b0;
            cap_rgb <= 24'h0;
        end else begin
            clk_q <= pixel_output_clock;
            if (pixel_output_clock && !clk_q) begin
                cap_rgb <= {red, green, blue};
            end
        end
    end
endmodule
`default_nettype wire

// ---- isp_tb_top.sv ----
// self-checking testbench for the interface select and power mode block
// assumes isp_top, the bound checker and the scaler model are compiled
`timescale 1ns/10ps
`default_nettype none
module interface_select_power_mode_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        det_hs, det_vs, det_sog, det_link;
    logic        ana_hsync, dig_vsync, hs_out, vs_out, dclk;
    logic        ana_vsync, ana_csync_vsync, dig_hsync;
    logic [7:0]  paddr, red, green, blue;
    logic [31:0] pwdata, prdata;
    logic [23:0] dig_rgb, cap_rgb, ana_rgb;
    logic [9:0]  power_enable;
    logic [1:0]  active_interface;
    int          fail_count, comparisons, cyc;
    isp_top isp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .det_hsync_active(det_hs), .det_vsync_active(det_vs),
        .det_sog_active(det_sog), .det_link_clock(det_link),
        .ana_rgb(ana_rgb), .ana_hsync(ana_hsync), .ana_vsync(ana_vsync),
        .ana_csync_vsync(ana_csync_vsync), .dig_rgb(dig_rgb),
        .dig_hsync(dig_hsync),
        .dig_vsync(dig_vsync), .red(red), .green(green), .blue(blue),
        .recovered_hsync_out(hs_out), .vertical_sync_out(vs_out),
        .pixel_output_clock(dclk), .power_enable(power_enable),
        .active_interface(active_interface));
    isp_scaler_model isp_scaler_model_inst (.pclk(pclk), .presetn(presetn),
        .pixel_output_clock(dclk), .red(red), .green(green), .blue(blue),
        .cap_rgb(cap_rgb));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // generous ceiling: the whole sequence needs well under 1000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            final_report;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        repeat (6) @(posedge pclk);
    endtask
    function automatic logic [9:0] pw_exp(input logic [1:0] act);
        return act == isp_pkg::ACT_DIG ? 10'h3df :
               act == isp_pkg::ACT_ANA ? 10'h3bf : 10'h00f;
    endfunction
    task automatic detect_table;
        logic [6:0]  tbl [7];
        logic [31:0] r;
        logic        e;
        tbl = '{7'b1000_0_01, 7'b0100_1_01, 7'b0010_1_01, 7'b0001_0_10,
                7'b1001_0_01, 7'b0011_1_10, 7'b0000_1_00};
        foreach (tbl[i]) begin
            {det_hs, det_sog, det_vs, det_link} <= tbl[i][6:3];
            wr(8'h3c, {30'h0, tbl[i][2], 1'b0});
            chk("act", 32'(active_interface), 32'(tbl[i][1:0]));
            chk("pwr", 32'(power_enable), 32'(pw_exp(tbl[i][1:0])));
            apb(1'b0, 8'h54, 32'h0, r, e);
            chk("det", 32'(r[7:4]), 32'(tbl[i][6:3]));
        end
    endtask
    task automatic override_power;
        logic [31:0] r;
        logic        e;
        wr(8'h3c, 32'h6);
        chk("ovr_dig", 32'(active_interface), 32'(isp_pkg::ACT_DIG));
        wr(8'h3c, 32'h4);
        chk("ovr_ana", 32'(power_enable), 32'h3bf);
        wr(8'h60, 32'h0531);
        chk("pwr_422", 32'(power_enable), 32'h1bf);
        chk("rgb_422", 32'({red, green, blue}), 32'h003c9600);
        wr(8'h50, 32'h0);
        chk("pwr_off", 32'(power_enable), 32'h001);
        apb(1'b0, 8'h64, 32'h0, r, e);
        chk("mode_off", 32'(r[4:0]), 32'(isp_pkg::MODE_OFF));
        wr(8'h50, 32'h2);
        wr(8'h60, 32'h0530);
    endtask
    task automatic output_path;
        dig_rgb   <= 24'ha5c35a;
        dig_vsync <= 1'b1;
        dig_hsync <= 1'b1;
        wr(8'h3c, 32'h6);
        repeat (12) @(posedge pclk);
        chk("hs_dig", 32'(hs_out), 32'h1);
        chk("rgb", 32'({red, green, blue}), 32'h00a5c35a);
        chk("cap", 32'(cap_rgb), 32'h00a5c35a);
        chk("vs", 32'(vs_out), 32'h1);
        wr(8'h40, 32'h44);
        repeat (6) @(posedge pclk);
        chk("vs_inv", 32'(vs_out), 32'h0);
    endtask
    // pulse width and start, at phase 0 and phase 3
    task automatic hsync_width;
        int n;
        int first;
        wr(8'h3c, 32'h4);
        for (int p = 0; p < 4; p += 3) begin
            n = 0;
            first = 0;
            wr(8'h60, 32'h0530 | (32'(p) << 2));
            ana_hsync <= 1'b1;
            repeat (2) @(posedge pclk);
            ana_hsync <= 1'b0;
            for (int j = 1; j <= 30; j++) begin
                @(posedge pclk);
                if (hs_out === 1'b1) begin
                    n++;
                    if (first == 0) begin
                        first = j;
                    end
                end
            end
            chk("hs_width", 32'(n), 32'h5);
            chk("hs_delay", 32'(first), 32'(p + 2));
        end
    endtask
    // vsync polarity bit is still set from output_path, so both sources flip the output
    task automatic analog_vsync;
        ana_vsync       <= 1'b0;
        ana_csync_vsync <= 1'b1;
        wr(8'h60, 32'h0532);
        chk("vs_comp", 32'(vs_out), 32'h0);
        wr(8'h60, 32'h0530);
        chk("vs_direct", 32'(vs_out), 32'h1);
    endtask
    task automatic after_reset;
        repeat (6) @(posedge pclk);
        chk("seek", 32'(power_enable), 32'h00f);
    endtask
    task automatic unmapped_read;
        logic [31:0] r;
        logic        e;
        apb(1'b0, 8'hfc, 32'h0, r, e);
        chk("err", 32'(e), 32'h1);
        chk("err_data", r, 32'h0);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {det_hs, det_vs, det_sog, det_link, ana_hsync, dig_vsync} = '0;
        dig_rgb = 24'h0;
        ana_rgb = 24'h3c9612;
        {ana_vsync, ana_csync_vsync, dig_hsync} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        after_reset;
        detect_table;
        override_power;
        output_path;
        hsync_width;
        analog_vsync;
        unmapped_read;
        final_report;
    end
endmodule
`default_nettype wire
